// [src/tocu_pkg.sv]
// constants, register map and mode decoding for the output compare unit
// Functional notes
// - compare the full 16-bit compare pair against the 16-bit timer count.
// - on a match do exactly one action chosen by the mode field.
// - every compare mode sets the unit's compare flag on a match.
// - second unit's pin goes to one of two port pins by select bit.
// - writing zero to the control register forces the compare latch low.
// - mode 1010 sets the flag on a match and leaves the pin alone.
// - mode 1011 resets the timer on a match and leaves the pin alone.
// - special event starts a conversion on second unit only, if enabled.
// - special event trigger asserts in the cycle the count becomes equal.
// - the timer reset lands on the next timer clock edge; period register.
// - a special event timer reset never sets the timer overflow flag.
// - removing the match before the timer edge cancels the pending reset.
// - compare needs the system clock; it stops when that clock stops.
// - mode 0010 toggles, 1000 sets, 1001 clears the output; flag set.
// - mode 0000 switches the unit off and resets its internal state.
package tocu_pkg;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CTL_W = 6;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned MODE_W = 4;
    // register indices; each unit takes a block of four
    localparam logic [ADDR_W-1:0] OFF_CTL = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_LOW = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_HIGH = 3'h2;
    localparam logic [ADDR_W-1:0] UNIT_STRIDE = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_PINSEL = 3'h7;
    localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;
    localparam logic [DATA_W-1:0] CMP_RESET = 8'h00;
    localparam int unsigned PINSEL_BIT = 0;
    // mode select codes
    localparam logic [MODE_W-1:0] MODE_OFF = 4'h0;
    localparam logic [MODE_W-1:0] MODE_TOGGLE = 4'h2;
    localparam logic [MODE_W-1:0] MODE_SET = 4'h8;
    localparam logic [MODE_W-1:0] MODE_CLEAR = 4'h9;
    localparam logic [MODE_W-1:0] MODE_SWINT = 4'ha;
    localparam logic [MODE_W-1:0] MODE_SPECIAL = 4'hb;

    // any of the five compare modes
    function automatic logic is_compare(input logic [MODE_W-1:0] m);
        return (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR) ||
               (m == MODE_SWINT) || (m == MODE_SPECIAL);
    endfunction

    // only toggle, set and clear take the pin; 1010 and 1011 never do
    function automatic logic is_pin_mode(input logic [MODE_W-1:0] m);
        return (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR);
    endfunction

    // register index of a field inside unit u
    function automatic logic [ADDR_W-1:0] unit_addr(input logic u,
            input logic [ADDR_W-1:0] off);
        return (u ? UNIT_STRIDE : 3'h0) + off;
    endfunction
endpackage

// [src/tocu_top.sv]
// output compare block: two compare units, byte registers and pin routing
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module tocu_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] timer_next,
    input wire logic timer_tick,
    input wire logic adc_enabled,
    input wire logic unit1_pin_dir,
    input wire logic port_c_pin_one_dir,
    input wire logic port_b_pin_three_dir,
    output logic unit1_pin_out,
    output logic unit1_pin_oe_n,
    output logic port_c_pin_one_out,
    output logic port_c_pin_one_oe_n,
    output logic port_b_pin_three_out,
    output logic port_b_pin_three_oe_n,
    output logic special_event1,
    output logic special_event2,
    output logic timer_clear_req1,
    output logic timer_clear_req2,
    output logic adc_start,
    output logic compare_irq_flag1,
    output logic compare_irq_flag2
);
    // all state runs on the one system clock, so nothing here advances
    // while that clock is stopped in sleep

    logic [5:0] ctl [2];
    logic [7:0] cmp_lo [2];
    logic [7:0] cmp_hi [2];
    logic [1:0] flag;
    logic pin_sel;

    logic [5:0] next_ctl [2];
    logic [7:0] next_lo [2];
    logic [7:0] next_hi [2];
    logic [15:0] next_cmp [2];
    logic [1:0] hit;
    logic [1:0] latch;
    logic [1:0] trig;
    logic [1:0] clr;
    logic [1:0] conv;
    logic [1:0] drive;

    // per-unit register decode, interface hookup and compare channel
    for (genvar i = 0; i < 2; i++) begin : g_unit
        tocu_unit_if uif ();
        wire logic sel_ctl = reg_addr ==
            tocu_pkg::unit_addr(i[0], tocu_pkg::OFF_CTL);
        wire logic sel_lo = reg_addr ==
            tocu_pkg::unit_addr(i[0], tocu_pkg::OFF_LOW);
        wire logic sel_hi = reg_addr ==
            tocu_pkg::unit_addr(i[0], tocu_pkg::OFF_HIGH);

        // writes land at the edge; units see the value being written
        assign next_ctl[i] = (reg_wr && sel_ctl) ?
            reg_wdata[tocu_pkg::CTL_W-1:0] : ctl[i];
        assign next_lo[i] = (reg_wr && sel_lo) ? reg_wdata : cmp_lo[i];
        assign next_hi[i] = (reg_wr && sel_hi) ? reg_wdata : cmp_hi[i];
        assign next_cmp[i] = {next_hi[i], next_lo[i]};

        assign uif.mode_next = next_ctl[i][tocu_pkg::MODE_W-1:0];
        assign uif.cmp_next = next_cmp[i];
        assign uif.timer_next = timer_next;
        assign uif.timer_tick = timer_tick;
        // conversion start exists on the second unit only
        assign uif.conv_enable = (i == 1) && adc_enabled;
        assign hit[i] = uif.hit;
        assign latch[i] = uif.latch;
        assign trig[i] = uif.trigger;
        assign clr[i] = uif.clear_req;
        assign conv[i] = uif.conv_start;
        // pin is taken only in toggle, set and clear modes
        assign drive[i] = tocu_pkg::is_pin_mode(
            ctl[i][tocu_pkg::MODE_W-1:0]);

        tocu_unit u_unit (
            .clk(clk),
            .rst(rst),
            .u(uif.unit)
        );

        // control and compare bytes
        always_ff @(posedge clk) begin
            if (rst) begin
                ctl[i] <= tocu_pkg::CTL_RESET;
                cmp_lo[i] <= tocu_pkg::CMP_RESET;
                cmp_hi[i] <= tocu_pkg::CMP_RESET;
            end else begin
                ctl[i] <= next_ctl[i];
                cmp_lo[i] <= next_lo[i];
                cmp_hi[i] <= next_hi[i];
            end
        end
    end

    // status and pin select decode
    wire logic sel_status = reg_addr == tocu_pkg::ADDR_STATUS;
    wire logic sel_pinsel = reg_addr == tocu_pkg::ADDR_PINSEL;
    wire logic [1:0] flag_clr = (reg_wr && sel_status) ?
        reg_wdata[1:0] : 2'h0;
    // a match in the clearing cycle still leaves the flag set
    wire logic [1:0] next_flag = hit | (flag & ~flag_clr);
    wire logic next_pin_sel = (reg_wr && sel_pinsel) ?
        reg_wdata[tocu_pkg::PINSEL_BIT] : pin_sel;

    // read mux; unmapped indices read zero, bits 7:6 of control read zero
    wire logic [7:0] rd_mux =
        (reg_addr == tocu_pkg::unit_addr(1'b0, tocu_pkg::OFF_CTL)) ?
            {2'h0, ctl[0]} :
        (reg_addr == tocu_pkg::unit_addr(1'b0, tocu_pkg::OFF_LOW)) ?
            cmp_lo[0] :
        (reg_addr == tocu_pkg::unit_addr(1'b0, tocu_pkg::OFF_HIGH)) ?
            cmp_hi[0] :
        (reg_addr == tocu_pkg::unit_addr(1'b1, tocu_pkg::OFF_CTL)) ?
            {2'h0, ctl[1]} :
        (reg_addr == tocu_pkg::unit_addr(1'b1, tocu_pkg::OFF_LOW)) ?
            cmp_lo[1] :
        (reg_addr == tocu_pkg::unit_addr(1'b1, tocu_pkg::OFF_HIGH)) ?
            cmp_hi[1] :
        sel_status ? {6'h00, flag} :
        sel_pinsel ? {7'h00, pin_sel} : 8'h00;

    // pin enables are active low; a pin left undriven floats as input
    wire logic drv_u1 = drive[0] && !unit1_pin_dir;
    wire logic drv_c1 = drive[1] && !pin_sel &&
        !port_c_pin_one_dir;
    wire logic drv_b3 = drive[1] && pin_sel && !port_b_pin_three_dir;

    // flags, pin select and read data
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 2'h0;
            pin_sel <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            flag <= next_flag;
            pin_sel <= next_pin_sel;
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // pin outputs registered; one cycle behind the compare latch
    always_ff @(posedge clk) begin
        if (rst) begin
            unit1_pin_out <= 1'b0;
            unit1_pin_oe_n <= 1'b1;
            port_c_pin_one_out <= 1'b0;
            port_c_pin_one_oe_n <= 1'b1;
            port_b_pin_three_out <= 1'b0;
            port_b_pin_three_oe_n <= 1'b1;
        end else begin
            unit1_pin_out <= drv_u1 && latch[0];
            unit1_pin_oe_n <= !drv_u1;
            port_c_pin_one_out <= drv_c1 && latch[1];
            port_c_pin_one_oe_n <= !drv_c1;
            port_b_pin_three_out <= drv_b3 && latch[1];
            port_b_pin_three_oe_n <= !drv_b3;
        end
    end

    // event outputs come from unit flops so the trigger keeps its cycle;
    // clear requests are a separate path and never touch overflow
    assign special_event1 = trig[0];
    assign special_event2 = trig[1];
    assign timer_clear_req1 = clr[0];
    assign timer_clear_req2 = clr[1];
    assign adc_start = conv[1];
    assign compare_irq_flag1 = flag[0];
    assign compare_irq_flag2 = flag[1];

    // checking helpers: equality as the units see it, one cycle delayed
    wire logic [1:0] eq;
    logic [1:0] eq_q;
    assign eq[0] = tocu_pkg::is_compare(
        next_ctl[0][tocu_pkg::MODE_W-1:0]) && (timer_next == next_cmp[0]);
    assign eq[1] = tocu_pkg::is_compare(
        next_ctl[1][tocu_pkg::MODE_W-1:0]) && (timer_next == next_cmp[1]);
    always_ff @(posedge clk) begin
        if (rst) begin
            eq_q <= 2'h0;
        end else begin
            eq_q <= eq;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence rise0_s;
        eq[0] && !eq_q[0];
    endsequence
    sequence hit_then_flag0_s;
        hit[0] ##1 compare_irq_flag1;
    endsequence
    sequence trig_now1_s;
        special_event2 && timer_clear_req2;
    endsequence

    flag_on_match_a: assert property (
        rise0_s |=> hit_then_flag0_s)
        else $error("compare flag not set after match");
    single_action_a: assert property (
        hit[0] |=> !hit[0])
        else $error("match action repeated while equal");
    trigger_timing_a: assert property (
        special_event2 |-> $past(timer_next) == $past(next_cmp[1]))
        else $error("special event not in the equal cycle");
    toggle_latch_a: assert property (
        hit[0] && ctl[0][tocu_pkg::MODE_W-1:0] == tocu_pkg::MODE_TOGGLE
        |-> latch[0] != $past(latch[0]))
        else $error("toggle mode did not flip the latch");
    zero_write_a: assert property (
        reg_wr && reg_addr == tocu_pkg::OFF_CTL && reg_wdata == 8'h00
        |=> !latch[0] ##1 !unit1_pin_out)
        else $error("zero control write left latch high");
    swint_pin_a: assert property (
        (ctl[0][tocu_pkg::MODE_W-1:0] == tocu_pkg::MODE_SWINT) [*2]
        |-> unit1_pin_oe_n)
        else $error("software interrupt mode drove the pin");
    cancel_reset_a: assert property (
        timer_clear_req2 && !eq[1] |=> !timer_clear_req2)
        else $error("pending timer reset not cancelled");
    adc_gate_a: assert property (
        rise0_s ##0 !eq[1] |=> !adc_start)
        else $error("first unit started a conversion");
    adc_start_a: assert property (
        adc_start |-> special_event2 && $past(adc_enabled))
        else $error("conversion start without trigger or enable");
    period_reset_a: assert property (
        special_event2 |-> trig_now1_s)
        else $error("trigger without timer reset request");
    route_a: assert property (
        $past(pin_sel) |-> port_c_pin_one_oe_n)
        else $error("second unit drove the deselected pin");
endmodule

// [src/tocu_unit.sv]
// one compare channel: match detection, output latch and special event
`timescale 1ns/1ps
module tocu_unit (
    input wire logic clk,
    input wire logic rst,
    tocu_unit_if.unit u
);
    logic match_q;

    // compare against next values so flops change as equality begins
    wire logic cmp_mode = tocu_pkg::is_compare(u.mode_next);
    wire logic next_match = cmp_mode &&
        (u.timer_next == u.cmp_next);
    wire logic first = next_match && !match_q;
    wire logic special = u.mode_next == tocu_pkg::MODE_SPECIAL;
    wire logic off = u.mode_next == tocu_pkg::MODE_OFF;

    // one action per match, picked by the mode code
    wire logic next_latch = !first ? u.latch :
        (u.mode_next == tocu_pkg::MODE_TOGGLE) ? !u.latch :
        (u.mode_next == tocu_pkg::MODE_SET) ? 1'b1 :
        (u.mode_next == tocu_pkg::MODE_CLEAR) ? 1'b0 : u.latch;

    // pending timer reset held to the next timer edge, dropped on mismatch
    wire logic next_clear = (first && special) ? 1'b1 :
        (u.timer_tick || !next_match) ? 1'b0 : u.clear_req;

    // off or zero write wipes the latch and all match state
    always_ff @(posedge clk) begin
        if (rst || off) begin
            match_q <= 1'b0;
            u.latch <= 1'b0;
            u.hit <= 1'b0;
            u.trigger <= 1'b0;
            u.clear_req <= 1'b0;
            u.conv_start <= 1'b0;
        end else begin
            match_q <= next_match;
            u.latch <= next_latch;
            u.hit <= first;
            u.trigger <= first && special;
            u.clear_req <= next_clear;
            u.conv_start <= first && special && u.conv_enable;
        end
    end
endmodule

// [src/tocu_unit_if.sv]
// signals between the register side and one compare unit
`timescale 1ns/1ps
interface tocu_unit_if;
    logic [3:0] mode_next;
    logic [15:0] cmp_next;
    logic [15:0] timer_next;
    logic timer_tick;
    logic conv_enable;
    logic hit;
    logic latch;
    logic trigger;
    logic clear_req;
    logic conv_start;
    modport unit(input mode_next, input cmp_next, input timer_next,
        input timer_tick, input conv_enable, output hit, output latch,
        output trigger, output clear_req, output conv_start);
    modport ctrl(output mode_next, output cmp_next, output timer_next,
        output timer_tick, output conv_enable, input hit, input latch,
        input trigger, input clear_req, input conv_start);
endinterface

// [tb/tocu_timer_model.sv]
// event timer partner: 16-bit count with load, hold, divide and clear
`timescale 1ns/1ps
module tocu_timer_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic ld,
    input wire logic [15:0] ld_val,
    input wire logic hold,
    input wire logic div4,
    input wire logic clr1,
    input wire logic clr2,
    output logic [15:0] timer_next,
    output logic timer_tick,
    output logic [15:0] count,
    output logic ovf
);
    logic [1:0] phase;
    // synchronous tick, every edge or one in four like an fosc/4 source
    assign timer_tick = !hold && (!div4 || phase == 2'h3);
    // a pending clear beats counting at the timer edge
    assign timer_next = ld ? ld_val : !timer_tick ? count :
        (clr1 || clr2) ? 16'h0000 : count + 16'h0001;
    // overflow only on a real wrap, never on a clear
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= 2'h0;
            count <= 16'h0000;
            ovf <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            count <= timer_next;
            if (timer_tick && !ld && !clr1 && !clr2 && count == 16'hffff)
                ovf <= 1'b1;
        end
    end
endmodule

// [tb/tocu_top_tb.sv]
// self-checking bench for the output compare block
`timescale 1ns/1ps
module tocu_top_tb;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d, v;
    logic [15:0] timer_next, count, c, ld_val = 16'h0000;
    logic ld = 1'b0, hold = 1'b1, div4 = 1'b0, adc_enabled = 1'b0;
    logic unit1_pin_dir = 1'b0, port_c_pin_one_dir = 1'b0;
    logic port_b_pin_three_dir = 1'b0;
    logic timer_tick, ovf, unit1_pin_out, unit1_pin_oe_n, port_c_pin_one_out;
    logic port_c_pin_one_oe_n, port_b_pin_three_out, port_b_pin_three_oe_n;
    logic special_event1, special_event2, timer_clear_req1, timer_clear_req2;
    logic adc_start, compare_irq_flag1, compare_irq_flag2, lat, pin;
    logic [3:0] modes [6] = '{4'h2, 4'h8, 4'h0, 4'h2, 4'h9, 4'ha};
    logic [1:0] sp [3] = '{2'b11, 2'b01, 2'b10}; // {unit2, adc on}
    logic [2:0] base;
    int err_total = 0, comparisons = 0, adc_cnt = 0, adc0, i, j, k;

    tocu_top tocu_top_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .timer_next, .timer_tick, .adc_enabled, .unit1_pin_dir,
        .port_c_pin_one_dir, .port_b_pin_three_dir, .unit1_pin_out,
        .unit1_pin_oe_n, .port_c_pin_one_out, .port_c_pin_one_oe_n,
        .port_b_pin_three_out, .port_b_pin_three_oe_n, .special_event1,
        .special_event2, .timer_clear_req1, .timer_clear_req2, .adc_start,
        .compare_irq_flag1, .compare_irq_flag2);
    tocu_timer_model tocu_timer_model_i (.clk, .rst, .ld, .ld_val, .hold,
        .div4, .clr1(timer_clear_req1), .clr2(timer_clear_req2), .timer_next,
        .timer_tick, .count, .ovf);

    initial begin
        forever #50 clk = ~clk;
    end
    // conversion starts are pulses, so count them as they pass
    always @(posedge clk) begin
        if (!rst && adc_start === 1'b1)
            adc_cnt++;
    end

    function automatic logic next_latch(input logic [3:0] m, input logic l);
        case (m)
            4'h2: return !l;
            4'h8: return 1'b1;
            4'h9: return 1'b0;
            default: return l;
        endcase
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        x = reg_rdata;
    endtask
    // load the count; the new value is visible right after the edge
    task automatic load_t(input logic [15:0] x);
        @(posedge clk);
        ld <= 1'b1;
        ld_val <= x;
        @(posedge clk);
        ld <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog sized well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h1c151cca));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        step();
        for (i = 0; i < 8; i++) begin
            rd(3'(i), d);
            chk(d, 16'h0000);
        end
        chk({unit1_pin_out, unit1_pin_oe_n,
            port_b_pin_three_oe_n}, 3);
        for (i = 0; i < 2; i++) begin
            v = 8'($urandom);
            wr(3'(i * 4), v);
            rd(3'(i * 4), d);
            chk(d, v & 8'h3f);
            wr(3'(i * 4), 8'h00);
        end
        // a random mode may have matched the zero count; flags are sticky
        wr(3'h3, 8'h03);
        // unit 1 pin modes, off and software interrupt, with the count held equal after the match
        lat = 1'b0;
        foreach (modes[j]) begin
            c = 16'($urandom);
            load_t(~c);
            wr(3'h0, {4'h0, modes[j]});
            if (modes[j] == 4'h0) begin
                lat = 1'b0;
                continue;
            end
            wr(3'h1, c[7:0]);
            wr(3'h2, c[15:8]);
            load_t(c ^ (16'h0001 << $urandom_range(15)));
            repeat (3) step();
            chk(compare_irq_flag1, 0);
            load_t(c);
            step();
            lat = next_latch(modes[j], lat);
            pin = (modes[j] != 4'ha);
            chk(compare_irq_flag1, 1);
            repeat (4) step();
            chk({unit1_pin_out, unit1_pin_oe_n},
                {lat & pin, !pin});
            wr(3'h3, 8'h01);
            rd(3'h3, d);
            chk(d, 16'h0000);
        end
        wr(3'h0, 8'h00);
        // special event on each unit, converter on and off
        for (j = 0; j < 3; j++) begin
            base = sp[j][1] ? 3'h4 : 3'h0;
            c = 16'h0100 + 16'($urandom_range(16'hfe00));
            adc_enabled <= sp[j][0];
            load_t(~c);
            wr(base + 3'h1, c[7:0]);
            wr(base + 3'h2, c[15:8]);
            wr(base, 8'h0b);
            adc0 = adc_cnt;
            div4 <= sp[j][0];
            load_t(c - 16'd6);
            hold <= 1'b0;
            for (k = 0; k < 60 && count !== c; k++)
                step();
            chk({special_event1, special_event2},
                {!sp[j][1], sp[j][1]});
            chk({unit1_pin_oe_n, port_c_pin_one_oe_n}, 3);
            for (k = 0; k < 8 && count !== 16'h0000; k++)
                step();
            chk(count, 16'h0000);
            chk(ovf, 0);
            step();
            chk(16'(adc_cnt - adc0), sp[j] == 2'b11);
            chk(sp[j][1] ? compare_irq_flag2 :
                compare_irq_flag1, 1);
            hold <= 1'b1;
            wr(3'h3, 8'h03);
            wr(base, 8'h00);
        end
        // moving the compare value before the timer edge drops the clear
        c = 16'h0100 + 16'($urandom_range(16'hfe00));
        div4 <= 1'b0;
        load_t(~c);
        wr(3'h5, c[7:0]);
        wr(3'h6, c[15:8]);
        wr(3'h4, 8'h0b);
        load_t(c);
        chk(special_event2, 1);
        wr(3'h6, c[15:8] + 8'h01);
        repeat (2) step();
        hold <= 1'b0;
        repeat (4) step();
        chk(count, c + 16'd4);
        hold <= 1'b1;
        // second unit routed to either port pin
        wr(3'h4, 8'h00);
        load_t(~c);
        wr(3'h4, 8'h08);
        // the high byte was moved above, so meet the pair as it now stands
        load_t({c[15:8] + 8'h01, c[7:0]});
        repeat (2) step();
        chk({port_c_pin_one_out, port_c_pin_one_oe_n,
            port_b_pin_three_oe_n}, 3'b101);
        wr(3'h7, 8'h01);
        repeat (2) step();
        chk({port_b_pin_three_out, port_b_pin_three_oe_n,
            port_c_pin_one_oe_n}, 3'b101);
        port_b_pin_three_dir <= 1'b1;
        repeat (2) step();
        chk({port_b_pin_three_out, port_b_pin_three_oe_n}, 2'b01);
        wr(3'h4, 8'h00);
        rd(3'h3, d);
        chk(d[1], 1);
        chk({port_b_pin_three_oe_n, port_c_pin_one_oe_n}, 3);
        report_and_stop();
    end
endmodule
